// ### teiq_pkg.sv
// Constants for the tone event interrupt queue: register map, fields, resets.
// Assumes a single 200 MHz clock domain and an APB slave with 32-bit data.
// ****************************************
// How it works
// R1: Queue register bit 7 is high while any tone event waits in the queue.
// R2: A completed host read of the queue register removes the oldest entry; the pending flag clears once the queue is empty.
// R3: Pending flag reads low only when the internal event queue is empty.
// R4: Queue register bits six and five always read as zero.
// R5: Queue register sits at offset 0x410 and resets to all zeros.
// R6: Entries give the channel number in bits 4:0, oldest first, one per read.
// ****************************************
package teiq_pkg;
  // Printed offsets step by one per register: they are indices, byte address = 4 * index
  localparam logic [11:0] QUEUE_IDX      = 12'h410;
  localparam logic [11:0] TEST_IDX       = 12'h411;
  localparam logic [11:0] IRQ_STATUS_IDX = 12'h412;
  localparam logic [11:0] IRQ_MASK_IDX   = 12'h413;
  localparam logic [13:0] QUEUE_ADDR      = {QUEUE_IDX, 2'b00};
  localparam logic [13:0] TEST_ADDR       = {TEST_IDX, 2'b00};
  localparam logic [13:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [13:0] IRQ_MASK_ADDR   = {IRQ_MASK_IDX, 2'b00};
  // Field positions
  localparam int PEND_BIT     = 7;
  localparam int CHAN_MSB     = 4;
  localparam int TEST_IRQ_BIT = 0;
  localparam int ST_EVENT_BIT = 0;
  localparam int ST_OVF_BIT   = 1;
  // Reset values
  localparam logic [7:0] QUEUE_RST = 8'h00;
  localparam logic [7:0] TEST_RST  = 8'h00;
  localparam logic [1:0] MASK_RST  = 2'h0;
  localparam int CHAN_W = 5;
endpackage

// ### teiq_top.sv
// Tone event interrupt queue with APB register access and one level interrupt.
// Assumes tone detector event pulses arrive on CLK_I; a pending pulse on a
// channel is queued once per cycle, lowest channel first.
module teiq_top
  import teiq_pkg::*;
#(
  parameter int N_CHAN = 32,
  parameter int DEPTH  = 32
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [15:0]       PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic [N_CHAN-1:0] TONE_EVENT_I,
  output logic                   IRQ_O,
  output logic                   TEST_IRQ_O
);
  localparam int PW = $clog2(DEPTH);

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [15:0] a, input logic [13:0] reg_addr);
    hit = (a[15:14] == 2'b00) && (a[13:0] == reg_addr);
  endfunction

  logic acc;
  logic wr;
  logic rd_queue;
  assign acc      = PSEL_I && PENABLE_I;
  assign wr       = acc && PWRITE_I;
  assign rd_queue = acc && !PWRITE_I && hit(PADDR_I, QUEUE_ADDR);
  // Zero wait states: every access completes in its first access cycle
  assign PREADY_O = 1'b1;

  // ****************************************
  // Event capture
  // ****************************************
  // Events latch until they can enter the queue so a burst is not lost
  logic [N_CHAN-1:0]  pend_evt;
  logic [N_CHAN-1:0]  grant;
  logic [CHAN_W-1:0]  grant_idx;
  logic               grant_vld;
  always_comb begin
    grant     = '0;
    grant_idx = '0;
    grant_vld = 1'b0;
    for (int i = N_CHAN - 1; i >= 0; i--) begin
      if (pend_evt[i]) begin
        grant     = '0;
        grant[i]  = 1'b1;
        grant_idx = CHAN_W'(i);
        grant_vld = 1'b1;
      end
    end
  end

  // ****************************************
  // Queue storage
  // ****************************************
  logic [CHAN_W-1:0] mem [DEPTH];
  logic [PW-1:0]     wr_ptr;
  logic [PW-1:0]     rd_ptr;
  logic [PW:0]       count;
  logic              full;
  logic              empty;
  logic              push;
  logic              pop;
  assign full  = (count == (PW+1)'(DEPTH));
  assign empty = (count == '0);
  assign push  = grant_vld && !full;
  assign pop   = rd_queue && !empty; // R2 R6

  // A grant is consumed only when pushed; a full queue holds events back
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pend_evt <= '0;
    end else begin
      pend_evt <= (pend_evt & ~(push ? grant : '0)) | TONE_EVENT_I;
    end
  end

  // Channel number written in grant order, lowest pending channel first
  always_ff @(posedge CLK_I) begin
    if (push) begin
      mem[wr_ptr] <= grant_idx; // R6
    end
  end

  // Pointer wrap only works for power-of-two depth
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1; // R6
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop); // R3
    end
  end

  // Queue register view: flag high iff queue non-empty, bits 6:5 zero
  logic [7:0] queue_view;
  always_comb begin
    queue_view = QUEUE_RST; // R5
    queue_view[PEND_BIT] = !empty; // R1 R3
    if (!empty) begin
      queue_view[CHAN_MSB:0] = mem[rd_ptr]; // R6
    end
    queue_view[6:5] = 2'b00; // R4
  end

  // ****************************************
  // Control, test and interrupt registers
  // ****************************************
  logic [7:0] test_reg;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_set;
  assign irq_set[ST_EVENT_BIT] = push;
  assign irq_set[ST_OVF_BIT]   = grant_vld && full;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      test_reg <= TEST_RST;
      irq_mask <= MASK_RST;
    end else if (wr) begin
      if (hit(PADDR_I, TEST_ADDR)) begin
        test_reg <= PWDATA_I[7:0];
      end
      if (hit(PADDR_I, IRQ_MASK_ADDR)) begin
        irq_mask <= PWDATA_I[1:0];
      end
    end
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~((wr && hit(PADDR_I, IRQ_STATUS_ADDR)) ?
                     PWDATA_I[1:0] : 2'b00)) | irq_set;
    end
  end

  // Test bit forces the interrupt line so software can check wiring
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O      <= 1'b0;
      TEST_IRQ_O <= 1'b0;
    end else begin
      IRQ_O      <= |(irq_status & irq_mask) || test_reg[TEST_IRQ_BIT];
      TEST_IRQ_O <= test_reg[TEST_IRQ_BIT];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] next_prdata;
  logic        next_slverr;
  always_comb begin
    next_prdata = '0;
    next_slverr = 1'b0;
    if (hit(PADDR_I, QUEUE_ADDR)) begin
      next_prdata[7:0] = queue_view;
    end else if (hit(PADDR_I, TEST_ADDR)) begin
      next_prdata[7:0] = test_reg;
    end else if (hit(PADDR_I, IRQ_STATUS_ADDR)) begin
      next_prdata[1:0] = irq_status;
    end else if (hit(PADDR_I, IRQ_MASK_ADDR)) begin
      next_prdata[1:0] = irq_mask;
    end else begin
      next_slverr = 1'b1;
    end
  end

  // Read data sampled combinationally in the access cycle from the live view
  assign PRDATA_O  = (acc && !PWRITE_I) ? next_prdata : 32'h0000_0000;
  assign PSLVERR_O = acc && next_slverr;
endmodule

// ### teiq_top_properties.sv
// Checker bound to teiq_top: APB answer and queue word shape.
// Assumes the teiq_top ports exactly as the design declares them.
module teiq_chk
  import teiq_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        IRQ_O
);
  // ****
  // APB answer, queue read and reset checks
  // ****
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Queue read in its access cycle
  wire logic rd = PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == 16'(QUEUE_ADDR);
  sequence q_rd; rd; endsequence
  ready_high_a: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("pready low in access");
  zero_bits_a: assert property (q_rd |-> PRDATA_O[31:8] == 0 && PRDATA_O[6:5] == 0)
    else $error("unused queue bits set");
  flag_on_entry_a: assert property ((q_rd and PRDATA_O[4:0] != 0) |-> PRDATA_O[7])
    else $error("entry shown without flag");
  empty_read_a: assert property ((q_rd and !PRDATA_O[7]) |-> PRDATA_O[7:0] == 0)
    else $error("empty read not zero");
  reset_quiet_a: assert property ($rose(RST_N_I) |-> !IRQ_O)
    else $error("irq high after reset");
  // Read data must be quiet outside a read access, so stale queue words never leak
  prdata_idle_a: assert property (!(PSEL_I && PENABLE_I && !PWRITE_I) |-> PRDATA_O == 0)
    else $error("read data outside read access");
endmodule
bind teiq_top teiq_chk i_teiq_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .IRQ_O(IRQ_O));

// ### test_tone_event_interrupt_queue.sv
// Bench for teiq_top: random tone bursts read back over APB, interrupt path.
// Assumes the design answers each access with pready.
module test_tone_event_interrupt_queue
  import teiq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err, pready, pslverr, irq, tirq;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v, tone = 0;
  int          mismatches = 0, samples_checked = 0;
  logic [4:0]  q[$];
  always #2.5 clk = ~clk;
  teiq_top i_teiq_top (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TONE_EVENT_I(tone), .IRQ_O(irq),
    .TEST_IRQ_O(tirq));
  // ****
  // Bus and compare tasks
  // ****
  // Request held until pready is seen; data taken at that same edge
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, 16'(a), d};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1 && ++n < 50);
    if (n >= 50) mismatches++;
    {rd, err} = {prdata, pslverr};
    {psel, pen} <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Queue word for a pending entry
  function automatic logic [31:0] qword(input logic [4:0] c);
    return {24'h0, 3'b100, c};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #100us;
    mismatches++;
    close_out();
  end
  initial begin
    void'($urandom(73));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    apb(0, QUEUE_ADDR, 0);
    chk("queue", 0, rd);
    apb(0, TEST_ADDR, 0);
    chk("test", 0, rd);
    $display("reset test done");
    // First burst fills all 32 places; a write to the queue must not disturb it
    for (int i = 0; i < 4; i++) begin
      v = i == 0 ? '1 : $urandom;
      tone <= v;
      @(posedge clk);
      tone <= 0;
      for (int k = 0; k < 32; k++) if (v[k]) q.push_back(5'(k));
      repeat (40) @(posedge clk);
      apb(1, QUEUE_ADDR, '1);
      while (q.size() > 0) begin
        apb(0, QUEUE_ADDR, 0);
        chk("entry", qword(q.pop_front()), rd);
      end
      apb(0, QUEUE_ADDR, 0);
      chk("drained", 0, rd);
    end
    $display("burst test done");
    // Interrupt raised, masked, cleared
    apb(1, IRQ_STATUS_ADDR, 3);
    apb(1, IRQ_MASK_ADDR, 1);
    v = $urandom % 32;
    tone <= 32'h1 << v;
    @(posedge clk);
    tone <= 0;
    repeat (4) @(negedge clk);
    chk("irq", 1, 32'(irq));
    apb(0, IRQ_STATUS_ADDR, 0);
    chk("status", 1, rd);
    apb(1, IRQ_MASK_ADDR, 0);
    repeat (2) @(negedge clk);
    chk("masked", 0, 32'(irq));
    apb(1, IRQ_STATUS_ADDR, 1);
    apb(1, IRQ_MASK_ADDR, 1);
    repeat (2) @(negedge clk);
    chk("cleared", 0, 32'(irq));
    apb(0, QUEUE_ADDR, 0);
    chk("entry", qword(v[4:0]), rd);
    apb(0, 14'h0, 0);
    chk("unmapped", 1, {rd[30:0], err});
    apb(1, TEST_ADDR, 1);
    repeat (2) @(negedge clk);
    chk("test irq", 3, {30'h0, tirq, irq});
    $display("irq test done");
    close_out();
  end
endmodule
